// ===== core/dibo_core.sv
// Mode register info/feature registers with burst column order generator
`timescale 1ns/10ps
`default_nettype none
module dibo_core (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode register command and read answer
    input wire dibo_pkg::dibo_cmd_t cmd,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_strobe,
    // Device status inputs
    input wire logic init_busy,
    input wire logic cal_pin_supply,
    input wire logic cal_pin_ground,
    // Burst request and column output
    input wire dibo_pkg::dibo_burst_t burst,
    output logic [9:0] col_out,
    output logic col_valid,
    output logic precharge_start,
    output logic factory_trim
);
    import dibo_pkg::*;

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    logic [7:0] feature_reg, feature_next;
    logic [1:0] selftest_reg, selftest_next;
    logic auto_init_reg, auto_init_next;
    logic [7:0] cal_cnt_reg, cal_cnt_next;
    logic cal_busy_reg, cal_busy_next;
    logic [7:0] rd_data_reg, rd_data_next;
    logic rd_valid_reg, rd_valid_next;
    logic trim_reg, trim_next;
    logic cal_ignored;

    // Calibration commands are ignored after an assembly fault
    assign cal_ignored = (selftest_reg == DIBO_ST_SUPPLY) || (selftest_reg == DIBO_ST_GROUND);

    // Register next values
    always_comb begin
        feature_next = feature_reg;
        selftest_next = selftest_reg;
        auto_init_next = init_busy;
        cal_cnt_next = cal_cnt_reg;
        cal_busy_next = cal_busy_reg;
        rd_data_next = DIBO_UNDEF_DATA;
        rd_valid_next = cmd.rd;
        if (cmd.wr && cmd.addr == DIBO_MA_FEATURE) begin
            feature_next = cmd.data;
        end
        if (cmd.wr && cmd.addr == DIBO_MA_CAL && cmd.data == DIBO_CAL_INIT_CODE
            && !cal_ignored && !cal_busy_reg) begin
            cal_busy_next = 1'b1;
            cal_cnt_next = DIBO_CAL_CYCLES;
        end else if (cal_busy_reg) begin
            cal_cnt_next = cal_cnt_reg - 8'h01;
            if (cal_cnt_reg == 8'h01) begin
                cal_busy_next = 1'b0;
                // 11 only means a resistor is present
                if (cal_pin_supply) begin
                    selftest_next = DIBO_ST_SUPPLY;
                end else if (cal_pin_ground) begin
                    selftest_next = DIBO_ST_GROUND;
                end else begin
                    selftest_next = DIBO_ST_OK;
                end
            end
        end
        if (cmd.rd && cmd.addr == DIBO_MA_INFO) begin
            rd_data_next = 8'h00;
            rd_data_next[DIBO_INFO_AUTO_INIT_POS] = auto_init_reg;
            rd_data_next[DIBO_INFO_SELFTEST_LSB +: 2] = selftest_reg;
        end
        trim_next = cal_ignored;
    end

    // Register update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            feature_reg <= DIBO_FEATURE_RESET;
            selftest_reg <= DIBO_SELFTEST_RESET;
            auto_init_reg <= 1'b1;
            cal_cnt_reg <= 8'h00;
            cal_busy_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
            trim_reg <= 1'b0;
        end else begin
            feature_reg <= feature_next;
            selftest_reg <= selftest_next;
            auto_init_reg <= auto_init_next;
            cal_cnt_reg <= cal_cnt_next;
            cal_busy_reg <= cal_busy_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            trim_reg <= trim_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_strobe = rd_valid_reg;
    assign factory_trim = trim_reg;

    // ------------------------------------------------------------
    // Burst order generator
    // ------------------------------------------------------------
    dibo_state_t state_reg, state_next;
    logic [9:0] base_reg, base_next;
    logic [3:0] start_reg, start_next;
    logic [3:0] beat_reg, beat_next;
    logic [3:0] last_reg, last_next;
    logic [3:0] wr_cnt_reg, wr_cnt_next;
    logic ap_reg, ap_next;
    logic [9:0] col_reg, col_next;
    logic col_valid_reg, col_valid_next;
    logic pre_reg, pre_next;
    logic [3:0] len_mask, offset;
    logic [3:0] wr_cycles;

    // length decode; reserved codes fall back to 4
    always_comb begin
        case (feature_reg[2:0])
            DIBO_BL8: len_mask = 4'h7;
            DIBO_BL16: len_mask = 4'hF;
            default: len_mask = 4'h3;
        endcase
    end

    assign wr_cycles = {1'b0, feature_reg[7:5]} + DIBO_WR_CODE_OFFSET;

    // Per-beat column offset
    always_comb begin
        if (feature_reg[DIBO_FEAT_TYPE_POS]) begin
            offset = (start_reg ^ beat_reg) & len_mask;
        end else begin
            offset = (start_reg + beat_reg) & len_mask;
        end
    end

    // Burst sequencing
    always_comb begin
        state_next = state_reg;
        base_next = base_reg;
        start_next = start_reg;
        beat_next = beat_reg;
        last_next = last_reg;
        wr_cnt_next = wr_cnt_reg;
        ap_next = ap_reg;
        col_next = col_reg;
        col_valid_next = 1'b0;
        pre_next = 1'b0;
        case (state_reg)
            DIBO_IDLE: begin
                if (burst.start) begin
                    start_next = burst.column[3:0] & len_mask & 4'hE;
                    base_next = {burst.column[9:1], 1'b0} & ~{6'h00, len_mask};
                    beat_next = 4'h0;
                    last_next = len_mask;
                    ap_next = burst.is_write && burst.auto_precharge;
                    if (feature_reg[DIBO_FEAT_WRAP_POS]) begin
                        base_next = {burst.column[9:1], 1'b0};
                        start_next = 4'h0;
                    end
                    state_next = DIBO_BURST;
                end
            end
            DIBO_BURST: begin
                col_valid_next = 1'b1;
                if (feature_reg[DIBO_FEAT_WRAP_POS]) begin
                    col_next = base_reg + {6'h00, beat_reg};
                end else begin
                    col_next = base_reg | {6'h00, offset};
                end
                beat_next = beat_reg + 4'h1;
                if (beat_reg == last_reg) begin
                    wr_cnt_next = wr_cycles;
                    state_next = ap_reg ? DIBO_RECOVER : DIBO_IDLE;
                end
            end
            DIBO_RECOVER: begin
                wr_cnt_next = wr_cnt_reg - 4'h1;
                if (wr_cnt_reg == 4'h1) begin
                    pre_next = 1'b1;
                    state_next = DIBO_IDLE;
                end
            end
            default: state_next = DIBO_IDLE;
        endcase
    end

    // Burst state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= DIBO_IDLE;
            base_reg <= 10'h000;
            start_reg <= 4'h0;
            beat_reg <= 4'h0;
            last_reg <= 4'h0;
            wr_cnt_reg <= 4'h0;
            ap_reg <= 1'b0;
            col_reg <= 10'h000;
            col_valid_reg <= 1'b0;
            pre_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            base_reg <= base_next;
            start_reg <= start_next;
            beat_reg <= beat_next;
            last_reg <= last_next;
            wr_cnt_reg <= wr_cnt_next;
            ap_reg <= ap_next;
            col_reg <= col_next;
            col_valid_reg <= col_valid_next;
            pre_reg <= pre_next;
        end
    end

    assign col_out = col_reg;
    assign col_valid = col_valid_reg;
    assign precharge_start = pre_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_info_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd.rd && cmd.addr == DIBO_MA_INFO) |=> (rd_data[7:5] == 3'h0 && rd_data[2:1] == 2'h0))
        else $error("info read reserved or fixed bits not zero");
    chk_auto_init_bit: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd.rd && cmd.addr == DIBO_MA_INFO) |=> rd_data[0] == $past(auto_init_reg))
        else $error("auto init bit wrong");
    chk_feature_load: assert property (@(posedge clk) disable iff (!reset_n)
        (cmd.wr && cmd.addr == DIBO_MA_FEATURE) |=> feature_reg == $past(cmd.data))
        else $error("feature register not loaded");
    chk_read_strobe: assert property (@(posedge clk) disable iff (!reset_n)
        cmd.rd |=> rd_strobe && rd_valid)
        else $error("no strobe on read");
    chk_trim_lock: assert property (@(posedge clk) disable iff (!reset_n)
        (cal_ignored && !cal_busy_reg) |=> !cal_busy_reg)
        else $error("calibration started while locked out");
    chk_col_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (col_valid && state_reg == DIBO_BURST && !feature_reg[DIBO_FEAT_TYPE_POS]
         && !feature_reg[DIBO_FEAT_WRAP_POS] && $past(beat_reg) == 4'h0) |-> col_out[0] == 1'b0)
        else $error("first beat column bit zero set");
    chk_nowrap_step: assert property (@(posedge clk) disable iff (!reset_n)
        (col_valid && $past(col_valid) && feature_reg[DIBO_FEAT_WRAP_POS]) |-> col_out == $past(col_out) + 10'h001)
        else $error("non-wrapping columns not consecutive");
    chk_precharge_delay: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg == DIBO_RECOVER && $past(state_reg) == DIBO_BURST) |-> ##[0:8] precharge_start)
        else $error("precharge not issued after recovery");
endmodule
`default_nettype wire

// ===== core/dibo_pkg.sv
// Package for the mode register info and burst order block
package dibo_pkg;
    // ------------------------------------------------------------
    // Mode addresses and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] DIBO_MA_INFO = 8'h00;
    localparam logic [7:0] DIBO_MA_FEATURE = 8'h01;
    // Mode address of the init calibration command (arbitrary choice)
    localparam logic [7:0] DIBO_MA_CAL = 8'h0A;
    localparam logic [7:0] DIBO_CAL_INIT_CODE = 8'hFF;
    localparam int DIBO_INFO_AUTO_INIT_POS = 0;
    localparam int DIBO_INFO_DEVTYPE_POS = 1;
    localparam int DIBO_INFO_DNV_POS = 2;
    localparam int DIBO_INFO_SELFTEST_LSB = 3;
    localparam int DIBO_FEAT_WRAP_POS = 4;
    localparam int DIBO_FEAT_TYPE_POS = 3;
    // Reset values
    localparam logic [7:0] DIBO_FEATURE_RESET = 8'h22;
    localparam logic [1:0] DIBO_SELFTEST_RESET = 2'h0;
    // Burst length codes
    localparam logic [2:0] DIBO_BL4 = 3'h2;
    localparam logic [2:0] DIBO_BL8 = 3'h3;
    localparam logic [2:0] DIBO_BL16 = 3'h4;
    // Self-test results
    localparam logic [1:0] DIBO_ST_NONE = 2'h0;
    localparam logic [1:0] DIBO_ST_SUPPLY = 2'h1;
    localparam logic [1:0] DIBO_ST_GROUND = 2'h2;
    localparam logic [1:0] DIBO_ST_OK = 2'h3;
    // Write recovery code offset: code 1 means 3 clocks
    localparam logic [3:0] DIBO_WR_CODE_OFFSET = 4'h2;
    // Calibration run length in cycles (arbitrary)
    localparam logic [7:0] DIBO_CAL_CYCLES = 8'h10;
    // Value read from write-only or reserved registers
    localparam logic [7:0] DIBO_UNDEF_DATA = 8'h00;

    // Mode register command
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } dibo_cmd_t;

    // Burst request
    typedef struct packed {
        logic start;
        logic is_write;
        logic auto_precharge;
        logic [9:0] column;
    } dibo_burst_t;

    typedef enum logic [1:0] {
        DIBO_IDLE = 2'b00,
        DIBO_BURST = 2'b01,
        DIBO_RECOVER = 2'b10
    } dibo_state_t;
endpackage

// ===== verif/dibo_ctrl_model.sv
// Memory controller model issuing mode register commands and bursts
`timescale 1ns/10ps
`default_nettype none
module dibo_ctrl_model (
    // Clock
    input wire logic clk,
    // Requests towards the device
    output logic [17:0] cmd_bits,
    output logic [12:0] burst_bits
);
    import dibo_pkg::*;
    dibo_cmd_t cmd;
    dibo_burst_t burst;
    assign cmd_bits = cmd;
    assign burst_bits = burst;
    // Idle at time zero
    initial begin
        cmd = '0;
        burst = '0;
    end
    // command pulse only
    // Released address, data and column show the inverse so stale values never pass
    task automatic mr_access(input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cmd <= '{rd: rd, wr: !rd, addr: a, data: d};
        @(negedge clk);
        cmd <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic burst_go(input logic [9:0] col, input logic ap);
        @(negedge clk);
        burst <= '{start: 1'b1, is_write: ap, auto_precharge: ap, column: col};
        @(negedge clk);
        burst <= '{start: 1'b0, is_write: 1'b0, auto_precharge: 1'b0, column: ~col};
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench for the mode register info and burst order block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dibo_pkg::*;
    logic clk, reset_n, init_busy, cal_pin_supply, cal_pin_ground;
    logic [17:0] cmd_bits;
    logic [12:0] burst_bits;
    logic [7:0] rd_data;
    logic rd_valid, rd_strobe, col_valid, precharge_start, factory_trim;
    logic [9:0] col_out;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int last_beat, pre_at;
    logic [9:0] beats[$];
    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    dibo_ctrl_model u_ctrl (.clk(clk), .cmd_bits(cmd_bits), .burst_bits(burst_bits));
    dibo_core u_dut (.clk(clk), .reset_n(reset_n), .cmd(cmd_bits), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_strobe(rd_strobe), .init_busy(init_busy),
        .cal_pin_supply(cal_pin_supply), .cal_pin_ground(cal_pin_ground), .burst(burst_bits),
        .col_out(col_out), .col_valid(col_valid), .precharge_start(precharge_start),
        .factory_trim(factory_trim));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic sup, input logic gnd);
        @(negedge clk);
        reset_n = 1'b0;
        cal_pin_supply = sup;
        cal_pin_ground = gnd;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
    endtask
    // Answer stands one cycle, so look right after the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        u_ctrl.mr_access(1'b1, a, 8'h00);
        chk("rd_valid", 10'h001, {9'h000, rd_valid});
        chk("rd_strobe", 10'h001, {9'h000, rd_strobe});
        chk("rd_data", {2'h0, exp}, {2'h0, rd_data});
    endtask
    // Expected order is rebuilt from length, type and wrap bits
    task automatic run_burst(input logic [7:0] feat, input logic [9:0] col, input logic ap);
        int len, s;
        logic [9:0] e;
        u_ctrl.mr_access(1'b0, DIBO_MA_FEATURE, feat);
        len = 4 << (feat[2:0] - 3'h2);
        beats = {};
        pre_at = -1;
        u_ctrl.burst_go(col, ap);
        repeat (40) begin
            @(negedge clk);
            if (col_valid === 1'b1) begin
                beats.push_back(col_out);
                last_beat = cyc;
            end
            if (precharge_start === 1'b1) pre_at = cyc;
        end
        chk("beat count", 10'(len), 10'(beats.size()));
        s = int'(col[3:0]) & (len - 1) & 14;
        for (int k = 0; k < len; k++) begin
            if (feat[4]) e = (col & 10'h3FE) + 10'(k);
            else if (feat[3]) e = (col & ~10'(len - 1)) | 10'(s ^ k);
            else e = (col & ~10'(len - 1)) | 10'((s + k) & (len - 1));
            chk("column", e, beats[k]);
        end
        if (ap) chk("recovery", 10'(feat[7:5]) + 10'h002, 10'(pre_at - last_beat));
        else chk("no precharge", 10'h3FF, 10'(pre_at));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_info;
        init_busy = 1'b1;
        @(negedge clk);
        rd_chk(DIBO_MA_INFO, 8'h01);
        init_busy = 1'b0;
        @(negedge clk);
        rd_chk(DIBO_MA_INFO, 8'h00);
        u_ctrl.mr_access(1'b0, DIBO_MA_INFO, 8'hFF);
        rd_chk(DIBO_MA_INFO, 8'h00);
        rd_chk(DIBO_MA_FEATURE, DIBO_UNDEF_DATA);
        $display("test info done");
    endtask
    // Second run with pins cleared must not move a fault result
    task automatic t_cal;
        logic [1:0] st[3] = '{DIBO_ST_SUPPLY, DIBO_ST_GROUND, DIBO_ST_OK};
        for (int i = 0; i < 3; i++) begin
            do_reset(i == 0, i == 1);
            rd_chk(DIBO_MA_INFO, 8'h00);
            for (int n = 0; n < 2; n++) begin
                u_ctrl.mr_access(1'b0, DIBO_MA_CAL, DIBO_CAL_INIT_CODE);
                repeat (24) @(negedge clk);
                rd_chk(DIBO_MA_INFO, {3'h0, st[i], 3'h0});
                chk("factory_trim", {9'h000, i < 2}, {9'h000, factory_trim});
                cal_pin_supply = 1'b0;
                cal_pin_ground = 1'b0;
            end
        end
        $display("test cal done");
    endtask
    task automatic t_burst;
        run_burst(8'h23, 10'h006, 1'b0);
        run_burst(8'h2B, 10'h00E, 1'b0);
        run_burst(8'h24, 10'h01B, 1'b0);
        run_burst(8'h32, 10'h0F5, 1'b0);
        run_burst(8'h2A, 10'h002, 1'b0);
        for (int c = 1; c < 7; c++) begin
            run_burst({3'(c), 5'h02}, 10'h100, 1'b1);
        end
        $display("test burst done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        init_busy = 1'b1;
        cal_pin_supply = 1'b0;
        cal_pin_ground = 1'b0;
        do_reset(1'b0, 1'b0);
        t_info;
        t_cal;
        t_burst;
        final_report;
    end
    // Watchdog well past the roughly 700 cycles needed
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
endmodule
`default_nettype wire
